//--- src/epc_pkg.sv
// Purpose: constants and types for the eprom mode and program controller
// Assumes: 250 MHz system clock
// Notes:   times kept in their own unit, cycle counts derived from them except SETUP_CYC
package epc_pkg;

   localparam int CLK_MHZ             = 250;
   localparam int ADDR_W              = 10;
   localparam int DATA_W              = 8;

   // read timing, ns
   localparam int ACCESS_NS           = 450;
   localparam int GATE_NS             = 120;
   localparam int GATE_LAG_NS         = 330;
   localparam int FLOAT_NS            = 100;
   localparam int ACCESS_CYC          = (ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int GATE_CYC            = (GATE_NS * CLK_MHZ + 999) / 1000;
   localparam int GATE_LAG_CYC        = (GATE_LAG_NS * CLK_MHZ) / 1000;
   localparam int PRE_GATE_CYC        = ACCESS_CYC - GATE_CYC;
   localparam int FLOAT_CYC           = (FLOAT_NS * CLK_MHZ + 999) / 1000;

   // program pulse, ms
   localparam int PULSE_MS            = 50;
   localparam int PULSE_MAX_MS        = 55;
   localparam int PULSE_CYC           = PULSE_MS * CLK_MHZ * 1000;
   localparam int PULSE_MAX_CYC       = PULSE_MAX_MS * CLK_MHZ * 1000;
   localparam int SETUP_CYC           = 2;

   // reset values of the pins
   localparam logic RST_SEL_N         = 1'b1;
   localparam logic RST_GATE_N        = 1'b1;
   localparam logic RST_PROG_SUPPLY   = 1'b0;

   typedef enum logic [1:0] {
      EPC_OP_READ,
      EPC_OP_PROGRAM,
      EPC_OP_VERIFY
   } epc_op_t;

endpackage : epc_pkg

//--- src/epc_timer_if.sv
// Purpose: carrier between the controller and its cycle timer
// Assumes: one clock domain
// Notes:   load starts a count, done pulses when it expires
`timescale 1ns/100ps
interface epc_timer_if;
   logic        load;
   logic [31:0] count;
   logic        done;
   logic        busy;
   modport ctrl  (output load, output count, input done, input busy);
   modport timer (input load, input count, output done, output busy);
endinterface : epc_timer_if

//--- src/epc_timer.sv
// Purpose: down counter that times pin phases
// Assumes: count of at least one
// Notes:   done is a one-cycle pulse
`timescale 1ns/100ps
module epc_timer (
   // clock and reset
   input  wire logic  i_clk,
   input  wire logic  i_rst_n,
   // control
   epc_timer_if.timer tif
);
   logic [31:0] cnt_reg;
   logic        done_reg;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg  <= 32'h0000_0000;
         done_reg <= 1'b0;
      end else if (tif.load) begin
         cnt_reg  <= tif.count;
         done_reg <= 1'b0;
      end else begin
         done_reg <= (cnt_reg == 32'h0000_0001);
         if (cnt_reg != 32'h0000_0000) cnt_reg <= cnt_reg - 32'h0000_0001;
      end
   end

   assign tif.done = done_reg;
   assign tif.busy = (cnt_reg != 32'h0000_0000);

   a_done_once: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      tif.done |=> !tif.done) else $error("timer done longer than one cycle");
endmodule : epc_timer

//--- src/epc_ctrl.sv
// Purpose: host side controller driving a 1K x 8 uv eprom by its pins
// Assumes: user requests on the same clock; eprom data returns asynchronously
// Notes:   supply select high means programming level

`timescale 1ns/100ps

// Behaviour
// - five modes chosen by four control pins
// - programming supply high in program, verify
// - supply at normal level otherwise
// - select reference held low always
// - gate may lag select bounded time; gate falls 84 cycles (336 ns) after select, over GATE_LAG_CYC of 82
// - select high gives standby
// - host gates only one device's outputs
// - program mode: supply high, gate high
// - address and byte presented before pulse
// - one high pulse of nominal length
// - pulse never exceeds maximum width
// - one pulse per programmed location
// - select low with supply high inhibits
// - parallel devices may share one pulse
// - verify read allowed with supply high
module epc_ctrl #(
   parameter int PULSE_CYCLES = epc_pkg::PULSE_CYC,
   parameter int PULSE_LIMIT  = epc_pkg::PULSE_MAX_CYC
) (
   // clock and reset
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_n,
   // user request
   input  wire logic                        i_req,
   input  wire epc_pkg::epc_op_t            i_op,
   input  wire logic [epc_pkg::ADDR_W-1:0]  i_addr,
   input  wire logic [epc_pkg::DATA_W-1:0]  i_wdata,
   output logic                             o_busy,
   output logic                             o_done,
   output logic [epc_pkg::DATA_W-1:0]       o_rdata,
   output logic                             o_mismatch,
   // eprom pins
   output logic [epc_pkg::ADDR_W-1:0]       o_addr,
   input  wire logic [epc_pkg::DATA_W-1:0]  i_data,
   output logic [epc_pkg::DATA_W-1:0]       o_data,
   output logic                             o_data_oe,
   output logic                             o_chip_select_program_n,
   output logic                             o_gate_n,
   output logic                             o_select_reference,
   output logic                             o_prog_supply_high
);
   if (PULSE_CYCLES < 2 || PULSE_CYCLES > PULSE_LIMIT) begin : g_bad_pulse
      $error("pulse length outside the allowed width");
   end

   typedef enum logic [2:0] {
      ST_IDLE, ST_SELECT, ST_GATE, ST_FLOAT, ST_SETUP, ST_PULSE, ST_HOLD
   } epc_state_t;

   ////////////////////////////////////////////////////////////////////////
   // reset release and input sync
   logic [1:0]                  rst_sync_reg;
   logic                        rst_n;
   logic [epc_pkg::DATA_W-1:0]  din_s1_reg;
   logic [epc_pkg::DATA_W-1:0]  din_s2_reg;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) rst_sync_reg <= 2'b00;
      else          rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_n = rst_sync_reg[1];

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         din_s1_reg <= 8'h00;
         din_s2_reg <= 8'h00;
      end else begin
         din_s1_reg <= i_data;
         din_s2_reg <= din_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timer
   epc_timer_if tif ();
   epc_timer u_timer (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .tif     (tif)
   );

   ////////////////////////////////////////////////////////////////////////
   // state
   epc_state_t                  state_reg, state_next;
   epc_pkg::epc_op_t            op_reg;
   logic [epc_pkg::ADDR_W-1:0]  addr_reg;
   logic [epc_pkg::DATA_W-1:0]  wdata_reg;
   logic [epc_pkg::DATA_W-1:0]  rdata_reg;
   logic                        sel_n_reg, gate_n_reg, supply_reg, oe_reg;
   logic                        busy_reg, done_reg, mismatch_reg;

   wire take      = (state_reg == ST_IDLE) && i_req;
   wire is_prog   = (op_reg == epc_pkg::EPC_OP_PROGRAM);
   wire is_verify = (op_reg == epc_pkg::EPC_OP_VERIFY);
   wire supply_want = take ? (i_op != epc_pkg::EPC_OP_READ) :
                      (state_next == ST_FLOAT || state_next == ST_IDLE) ? 1'b0 : supply_reg;
   wire bad_bits  = |(~din_s2_reg & wdata_reg) | |(din_s2_reg & ~wdata_reg);

   always_comb begin
      state_next = state_reg;
      tif.load   = 1'b0;
      tif.count  = 32'h0000_0001;
      case (state_reg)
         ST_IDLE: begin
            if (i_req) begin
               tif.load = 1'b1;
               if (i_op == epc_pkg::EPC_OP_PROGRAM) begin
                  tif.count  = 32'(epc_pkg::SETUP_CYC);
                  state_next = ST_SETUP;
               end else begin
                  // select and address settle before gate
                  tif.count  = 32'(epc_pkg::PRE_GATE_CYC);
                  state_next = ST_SELECT;
               end
            end
         end
         ST_SELECT: begin
            if (tif.done) begin
               tif.load   = 1'b1;
               tif.count  = 32'(epc_pkg::GATE_CYC + 2);
               state_next = ST_GATE;
            end
         end
         ST_GATE: begin
            if (tif.done) begin
               tif.load   = 1'b1;
               tif.count  = 32'(epc_pkg::FLOAT_CYC);
               state_next = ST_FLOAT;
            end
         end
         ST_FLOAT:  if (tif.done) state_next = ST_IDLE;
         ST_SETUP: begin
            if (tif.done) begin
               tif.load   = 1'b1;
               // timer stays one cycle beyond its count
               tif.count  = 32'(PULSE_CYCLES - 1);
               state_next = ST_PULSE;
            end
         end
         ST_PULSE: begin
            if (tif.done) begin
               tif.load   = 1'b1;
               tif.count  = 32'(epc_pkg::SETUP_CYC);
               state_next = ST_HOLD;
            end
         end
         ST_HOLD:   if (tif.done) state_next = ST_IDLE;
         default:   state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= ST_IDLE;
         op_reg       <= epc_pkg::EPC_OP_READ;
         addr_reg     <= 10'h000;
         wdata_reg    <= 8'hFF;
         rdata_reg    <= 8'hFF;
         sel_n_reg    <= epc_pkg::RST_SEL_N;
         gate_n_reg   <= epc_pkg::RST_GATE_N;
         supply_reg   <= epc_pkg::RST_PROG_SUPPLY;
         oe_reg       <= 1'b0;
         busy_reg     <= 1'b0;
         done_reg     <= 1'b0;
         mismatch_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         done_reg  <= 1'b0;
         if (take) begin
            op_reg    <= i_op;
            addr_reg  <= i_addr;
            wdata_reg <= i_wdata;
            busy_reg  <= 1'b1;
         end
         supply_reg <= supply_want;
         case (state_next)
            ST_IDLE: begin
               sel_n_reg  <= 1'b1;
               gate_n_reg <= 1'b1;
               oe_reg     <= 1'b0;
            end
            ST_SELECT: begin
               sel_n_reg  <= 1'b0;
               gate_n_reg <= 1'b1;
               oe_reg     <= 1'b0;
            end
            ST_GATE: gate_n_reg <= 1'b0;
            ST_FLOAT: begin
               gate_n_reg <= 1'b1;
               sel_n_reg  <= 1'b1;
            end
            // gate high, byte driven, select low
            ST_SETUP: begin
               sel_n_reg  <= 1'b0;
               gate_n_reg <= 1'b1;
               oe_reg     <= 1'b1;
            end
            ST_PULSE: sel_n_reg <= 1'b1;
            ST_HOLD:  sel_n_reg <= 1'b0;
            default:  sel_n_reg <= 1'b1;
         endcase
         if (state_reg == ST_GATE && tif.done) begin
            rdata_reg    <= din_s2_reg;
            mismatch_reg <= is_verify && bad_bits;
         end
         if (state_reg != ST_IDLE && state_next == ST_IDLE) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            if (!is_verify) mismatch_reg <= 1'b0;
         end
      end
   end

   assign o_select_reference      = 1'b0;
   assign o_busy                  = busy_reg;
   assign o_done                  = done_reg;
   assign o_rdata                 = rdata_reg;
   assign o_mismatch              = mismatch_reg;
   assign o_addr                  = addr_reg;
   assign o_data                  = wdata_reg;
   assign o_data_oe               = oe_reg;
   assign o_chip_select_program_n = sel_n_reg;
   assign o_gate_n                = gate_n_reg;
   assign o_prog_supply_high      = supply_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic [31:0] pulse_len_reg;
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n)                              pulse_len_reg <= 32'h0000_0000;
      else if (state_reg == ST_PULSE && sel_n_reg) pulse_len_reg <= pulse_len_reg + 32'h1;
      else                                     pulse_len_reg <= 32'h0000_0000;
   end

   a_pulse_max_width: assert property (@(posedge i_clk) disable iff (!rst_n)
      pulse_len_reg <= 32'(PULSE_LIMIT)) else $error("program pulse too long");
   a_pulse_supply_high: assert property (@(posedge i_clk) disable iff (!rst_n)
      (state_reg == ST_PULSE) |-> o_prog_supply_high) else $error("pulse at normal supply");
   a_pulse_gate_high: assert property (@(posedge i_clk) disable iff (!rst_n)
      (state_reg == ST_PULSE) |-> o_gate_n && o_data_oe) else $error("pulse with gate low");
   a_read_supply_low: assert property (@(posedge i_clk) disable iff (!rst_n)
      (state_reg == ST_GATE && op_reg == epc_pkg::EPC_OP_READ) |-> !o_prog_supply_high)
      else $error("read at program supply");
   a_no_contention: assert property (@(posedge i_clk) disable iff (!rst_n)
      !(o_data_oe && !o_gate_n)) else $error("data driven while gated");
   a_ref_low: assert property (@(posedge i_clk) disable iff (!rst_n)
      !o_select_reference) else $error("select reference high");
   a_gate_after_select: assert property (@(posedge i_clk) disable iff (!rst_n)
      $fell(o_gate_n) |-> !o_chip_select_program_n && $past(!o_chip_select_program_n, 2))
      else $error("gate before select settled");
   a_float_wait: assert property (@(posedge i_clk) disable iff (!rst_n)
      $rose(o_gate_n) |-> !o_done [*2]) else $error("done before float time");
   a_idle_standby: assert property (@(posedge i_clk) disable iff (!rst_n)
      (state_reg == ST_IDLE && !o_busy) |-> o_chip_select_program_n)
      else $error("select low while idle");
   a_setup_before_pulse: assert property (@(posedge i_clk) disable iff (!rst_n)
      $rose(o_chip_select_program_n) && o_data_oe |-> $past(o_data_oe, 2))
      else $error("byte not set up before pulse");

   // select and gate low time counters
   logic [31:0] sel_low_reg;
   logic [31:0] gate_low_reg;
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_low_reg  <= 32'h0000_0000;
         gate_low_reg <= 32'h0000_0000;
      end else begin
         sel_low_reg  <= sel_n_reg ? 32'h0000_0000 : sel_low_reg + 32'h0000_0001;
         gate_low_reg <= gate_n_reg ? 32'h0000_0000 : gate_low_reg + 32'h0000_0001;
      end
   end

   a_standby_supply_low: assert property (@(posedge i_clk) disable iff (!rst_n)
      (o_chip_select_program_n && !o_data_oe) |-> !o_prog_supply_high)
      else $error("standby at program supply");
   a_pulse_nominal_width: assert property (@(posedge i_clk) disable iff (!rst_n)
      (state_reg == ST_HOLD && $past(state_reg) == ST_PULSE)
      |-> pulse_len_reg == 32'(PULSE_CYCLES)) else $error("program pulse not nominal");
   a_supply_before_pulse: assert property (@(posedge i_clk) disable iff (!rst_n)
      $rose(o_chip_select_program_n) && o_data_oe |-> $past(o_prog_supply_high))
      else $error("supply not raised before pulse");
   a_select_settled: assert property (@(posedge i_clk) disable iff (!rst_n)
      $fell(o_gate_n) |-> sel_low_reg >= 32'(epc_pkg::PRE_GATE_CYC))
      else $error("gate lowered before select settled");
   a_gate_long_enough: assert property (@(posedge i_clk) disable iff (!rst_n)
      (state_reg == ST_GATE && tif.done) |-> gate_low_reg >= 32'(epc_pkg::GATE_CYC))
      else $error("data taken before gate delay");
endmodule : epc_ctrl

//--- sim/epc_eprom_model.sv
// Purpose: behavioural 1k x 8 uv eprom seen at the controller pins
// Assumes: pin delays in ns, data bus without pull resistors
// Notes:   an undriven or unsettled bus shows the inverted stored byte
`timescale 1ns/100ps
module epc_eprom_model #(
   parameter int PULSE_MAX_NS = 88
) (
   // pins from the controller
   input  wire logic [epc_pkg::ADDR_W-1:0] i_addr,
   input  wire logic                       i_sel_n,
   input  wire logic                       i_gate_n,
   input  wire logic                       i_sel_ref,
   input  wire logic                       i_supply,
   input  wire logic [epc_pkg::DATA_W-1:0] i_host_d,
   input  wire logic                       i_host_oe,
   // resolved data bus and fault count
   output logic [epc_pkg::DATA_W-1:0]      o_bus,
   output int                              o_faults
);
   logic    [7:0] mem [1024];
   logic    [7:0] d_rise;
   logic          pulsing;
   realtime       t_rise;
   wire     [9:0] #(epc_pkg::ACCESS_NS) addr_d = i_addr;
   wire           #(epc_pkg::ACCESS_NS) sel_ok = ~i_sel_n;
   wire           #(epc_pkg::GATE_NS) gate_ok = ~i_gate_n;
   wire           valid;
   ////////////////////////////////////////////////////////////////////////////////
   // erased reads ones
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      o_faults = 0;
      pulsing = 1'b0;
   end
   assign valid = sel_ok & gate_ok & ~i_sel_n & ~i_gate_n & (addr_d == i_addr);
   assign o_bus = i_host_oe ? i_host_d : (valid ? mem[i_addr] : ~mem[i_addr]);
   ////////////////////////////////////////////////////////////////////////////////
   // pulse start, supply high
   always @(posedge i_sel_n) begin
      t_rise = $realtime;
      // let pins launched on the same edge settle
      #1;
      pulsing = i_supply & i_gate_n & i_host_oe;
      d_rise = i_host_d;
   end
   always @(negedge i_sel_n) begin
      if (pulsing) begin
         if ($realtime - t_rise > PULSE_MAX_NS || d_rise !== i_host_d) o_faults++;
         mem[i_addr] = mem[i_addr] & i_host_d;
         pulsing = 1'b0;
      end
   end
   always @(i_sel_ref, i_host_oe, i_sel_n, i_gate_n) begin
      if (i_sel_ref !== 1'b0 || (i_host_oe && !i_sel_n && !i_gate_n)) o_faults++;
   end
endmodule : epc_eprom_model

//--- sim/testbench.sv
// Purpose: self checking bench for the eprom mode and program controller
// Assumes: short program pulse for simulation
// Notes:   reference memory kept beside the device model
`timescale 1ns/100ps
module testbench;
   localparam int P = 20;
   logic             clk, rst_n, req, busy, done, mism, oe, sel_n, gate_n, sref, sup;
   epc_pkg::epc_op_t op;
   logic [9:0]       addr, pa;
   logic [7:0]       wd, rd, od, bus, d;
   logic [7:0]       ref_mem [1024];
   logic [31:0]      lfsr;
   int               n_errors, checked, pw, faults, sh;

   epc_ctrl #(.PULSE_CYCLES(P), .PULSE_LIMIT(22)) u_dut (
      .i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_op(op), .i_addr(addr),
      .i_wdata(wd), .o_busy(busy), .o_done(done), .o_rdata(rd), .o_mismatch(mism),
      .o_addr(pa), .i_data(bus), .o_data(od), .o_data_oe(oe),
      .o_chip_select_program_n(sel_n), .o_gate_n(gate_n),
      .o_select_reference(sref), .o_prog_supply_high(sup));
   epc_eprom_model #(.PULSE_MAX_NS(22 * 4)) u_mem (
      .i_addr(pa), .i_sel_n(sel_n), .i_gate_n(gate_n), .i_sel_ref(sref),
      .i_supply(sup), .i_host_d(od), .i_host_oe(oe), .o_bus(bus), .o_faults(faults));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (oe === 1'b1 && sel_n === 1'b1 && sup === 1'b1) pw++;
      if (sup === 1'b1) sh++;
   end
   initial begin
      #(4 * 20000);
      n_errors++;
      complete_run();
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   task automatic chk_val(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : chk_val
   task automatic chk_cnt(input string n, input int e, input int g);
      checked++;
      if (g != e) begin
         n_errors++;
         $display("unexpected %s: expected %0d seen %0d", n, e, g);
      end
   endtask : chk_cnt
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run
   // one operation; intr raises a request mid-operation that must be ignored
   task automatic run(input epc_pkg::epc_op_t o, input logic [9:0] a, input logic [7:0] v,
                      input bit intr);
      int k;
      @(negedge clk);
      op = o;
      addr = a;
      wd = v;
      req = 1'b1;
      pw = 0;
      sh = 0;
      @(negedge clk);
      req = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 400) begin
         @(negedge clk);
         k++;
         if (intr && k == 10) begin
            req = 1'b1;
            op = epc_pkg::EPC_OP_PROGRAM;
            addr = a ^ 10'h001;
            wd = 8'h00;
         end
         if (k == 13) req = 1'b0;
      end
      chk_val("done", 8'h01, {7'h00, done});
      chk_val("idle pins", 8'h06, {5'h00, sel_n, gate_n, oe});
      if (o == epc_pkg::EPC_OP_PROGRAM) ref_mem[a] = ref_mem[a] & v;
      if (o == epc_pkg::EPC_OP_PROGRAM) chk_cnt("pulse width", P, pw);
      if (o != epc_pkg::EPC_OP_PROGRAM) chk_val("rdata", ref_mem[a], rd);
      chk_val("supply raised", {7'h00, o != epc_pkg::EPC_OP_READ}, {7'h00, sh > 0});
      chk_val("supply after", 8'h00, {7'h00, sup});
      chk_val("mismatch", {7'h00, o == epc_pkg::EPC_OP_VERIFY && ref_mem[a] != v},
              {7'h00, mism});
   endtask : run
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      req = 1'b0;
      op = epc_pkg::EPC_OP_READ;
      addr = 10'h000;
      wd = 8'h00;
      lfsr = 32'h0000_21d2;
      n_errors = 0;
      checked = 0;
      pw = 0;
      foreach (ref_mem[i]) ref_mem[i] = 8'hff;
      repeat (20) @(negedge clk);
      chk_val("reset pins", 8'h18, {3'h0, sel_n, gate_n, oe, sup, sref});
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      run(epc_pkg::EPC_OP_READ, 10'h000, 8'h00, 1'b0);
      run(epc_pkg::EPC_OP_READ, 10'h3ff, 8'h00, 1'b0);
      run(epc_pkg::EPC_OP_PROGRAM, 10'h3ff, 8'h00, 1'b0);
      run(epc_pkg::EPC_OP_PROGRAM, 10'h000, 8'ha5, 1'b1);
      run(epc_pkg::EPC_OP_READ, 10'h001, 8'h00, 1'b0);
      run(epc_pkg::EPC_OP_READ, 10'h3ff, 8'h00, 1'b1);
      for (int i = 0; i < 10; i++) begin
         lfsr = lfsr_next(lfsr);
         d = lfsr[17:10];
         run(epc_pkg::EPC_OP_PROGRAM, lfsr[9:0], d, 1'b0);
         run(epc_pkg::EPC_OP_VERIFY, lfsr[9:0], d, 1'b0);
         run(epc_pkg::EPC_OP_PROGRAM, lfsr[9:0], lfsr[25:18], 1'b0);
         run(epc_pkg::EPC_OP_VERIFY, lfsr[9:0], lfsr[25:18], 1'b0);
         run(epc_pkg::EPC_OP_READ, lfsr[9:0], 8'h00, 1'b0);
      end
      chk_cnt("device faults", 0, faults);
      complete_run();
   end
endmodule : testbench
